// >>> rtc_pkg.sv
// shared constants and types for the calendar clock unit
package rtc_pkg;

    // ****************************************
    // register offsets (byte addresses)
    // ****************************************
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_SEC = 8'h04;
    localparam logic [7:0] OFF_MIN = 8'h08;
    localparam logic [7:0] OFF_HOUR = 8'h0C;
    localparam logic [7:0] OFF_DATE = 8'h10;
    localparam logic [7:0] OFF_WEEK = 8'h14;
    localparam logic [7:0] OFF_MONTH = 8'h18;
    localparam logic [7:0] OFF_YEAR = 8'h1C;
    localparam logic [7:0] OFF_CORR = 8'h20;
    localparam logic [7:0] OFF_AMIN = 8'h24;
    localparam logic [7:0] OFF_AHOUR = 8'h28;
    localparam logic [7:0] OFF_AWEEK = 8'h2C;
    localparam logic [7:0] OFF_STAT = 8'h30;
    localparam logic [7:0] OFF_MASK = 8'h34;
    localparam logic [7:0] OFF_REGEN = 8'h38;

    // ****************************************
    // field limits and periods
    // ****************************************
    localparam logic [5:0] SEC_MAX = 6'h3B;
    localparam logic [5:0] MIN_MAX = 6'h3B;
    localparam logic [4:0] HOUR_MAX = 5'h17;
    localparam logic [2:0] WEEK_MAX = 3'h6;
    localparam logic [3:0] MONTH_MAX = 4'hC;
    localparam logic [6:0] YEAR_MAX = 7'h63;
    localparam logic [3:0] MONTH_FEB = 4'h2;
    localparam int TICKS_PER_SEC = 32768;
    localparam logic [21:0] LP_MIN_SECS = 22'h00003C;
    localparam logic [21:0] LP_HOUR_SECS = 22'h000E10;
    localparam logic [21:0] LP_DAY_SECS = 22'h015180;
    localparam logic [21:0] LP_MONTH_SECS = 22'h278D00;

    // periodic interval select codes
    localparam logic [2:0] PER_OFF = 3'h0;
    localparam logic [2:0] PER_HALF = 3'h1;
    localparam logic [2:0] PER_SEC = 3'h2;
    localparam logic [2:0] PER_MIN = 3'h3;
    localparam logic [2:0] PER_HOUR = 3'h4;
    localparam logic [2:0] PER_DAY = 3'h5;
    localparam logic [2:0] PER_MONTH = 3'h6;

    // interrupt status bits
    localparam int EV_PER = 0;
    localparam int EV_ALM = 1;
    localparam int EV_FETCH = 2;

    // ****************************************
    // state types
    // ****************************************
    typedef struct packed {
        logic alm_en;
        logic [2:0] per_sel;
        logic hi_acc;
        logic out_en;
        logic clk_low;
        logic run;
    } ctrl_t;

    typedef struct packed {
        logic [6:0] year;
        logic [3:0] month;
        logic [4:0] date;
        logic [2:0] week;
        logic [4:0] hour;
        logic [5:0] min;
        logic [5:0] sec;
    } cal_t;

    typedef struct packed {
        logic [6:0] week;
        logic [4:0] hour;
        logic [5:0] min;
    } alarm_t;

    localparam ctrl_t CTRL_RST = '0;
    localparam logic [15:0] CORR_RST = 16'h0000;

    typedef struct packed {
        logic [2:0] sh;
    } sync_state_t;

    typedef struct packed {
        logic [17:0] cnt;
        logic [15:0] corr;
        logic half;
        logic sec;
        logic level;
    } presc_state_t;

endpackage

// >>> pin_edge_sync.sv
// two-flop synchroniser with rising-edge pulse for an oscillator pin
`timescale 1ns/10ps
module pin_edge_sync
    import rtc_pkg::*;
(
    input wire logic core_clk_i, // core clock
    input wire logic reset_n_i, // sync reset, active low
    input wire logic pin_i, // asynchronous oscillator pin
    output logic rise_o // one-cycle pulse per rising edge
);
    sync_state_t q;
    sync_state_t d;

    always_comb begin
        d.sh = {q.sh[1:0], pin_i};
    end

    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // edge taken only from second and third stage
    assign rise_o = q.sh[1] & ~q.sh[2];
endmodule

// >>> second_prescaler.sv
// divides the count clock to half-second and second ticks and the 1 Hz level
`timescale 1ns/10ps
module second_prescaler
    import rtc_pkg::*;
#(
    parameter int TICKS = TICKS_PER_SEC
) (
    input wire logic core_clk_i, // core clock
    input wire logic reset_n_i, // sync reset, active low
    input wire logic run_i, // counting enabled
    input wire logic tick_i, // one count-clock tick
    input wire logic hi_acc_i, // corrected period in use
    input wire logic [15:0] corr_i, // signed tick correction
    output logic half_o, // half-second pulse
    output logic sec_o, // second pulse
    output logic level_o // 1 Hz square wave
);
    localparam logic [17:0] BASE = 18'(TICKS);
    presc_state_t q;
    presc_state_t d;
    logic [17:0] limit;

    always_comb begin
        d = q;
        d.half = 1'b0;
        d.sec = 1'b0;
        limit = hi_acc_i ? BASE + {{2{q.corr[15]}}, q.corr} : BASE;
        if (!run_i) begin
            d.cnt = '0;
        end else if (tick_i) begin
            if (q.cnt >= limit - 18'h00001) begin
                d.cnt = '0;
                d.sec = 1'b1;
                d.corr = corr_i;
            end else begin
                d.cnt = q.cnt + 18'h00001;
            end
            if (q.cnt == {1'b0, limit[17:1]} - 18'h00001) begin
                d.half = 1'b1;
            end
        end
        d.level = run_i && (d.cnt < {1'b0, limit[17:1]});
    end

    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign half_o = q.half;
    assign sec_o = q.sec;
    assign level_o = q.level;
endmodule

// >>> calendar_clock_unit.sv
// calendar clock unit: counters, alarm, periodic event, 1 Hz pin, apb slave
`timescale 1ns/10ps
module calendar_clock_unit
    import rtc_pkg::*;
(
    input wire logic core_clk_i, // 25 MHz core clock
    input wire logic reset_n_i, // system reset, sync, active low
    input wire logic por_n_i, // power-on reset, sync, active low
    input wire logic sub_clk_i, // subsystem oscillator pin
    input wire logic low_speed_osc_clock_i, // low-speed oscillator pin
    input wire logic fast_onchip_oscillator_on_i, // fast oscillator running
    input wire logic psel_i, // apb select
    input wire logic penable_i, // apb enable
    input wire logic pwrite_i, // apb write
    input wire logic [7:0] paddr_i, // apb byte address
    input wire logic [31:0] pwdata_i, // apb write data
    output logic [31:0] prdata_o, // apb read data
    output logic pready_o, // apb ready
    output logic pslverr_o, // apb error
    output logic clock_event_interrupt_o, // level interrupt
    output logic wake_request_o, // deep-stop wakeup level
    output logic converter_low_power_mode_o, // converter trigger pulse
    output logic periodic_pulse_o, // periodic event pulse
    output logic one_hz_o // 1 Hz pin
);
    typedef struct packed {
        ctrl_t ctrl;
        logic [15:0] corr;
        logic reg_en;
        cal_t cal;
        alarm_t alm;
        logic [2:0] stat;
        logic [2:0] mask;
        logic alm_hit;
        logic [21:0] lp_cnt;
        logic per_pulse;
        logic conv_trig;
        logic irq;
        logic one_hz;
        logic [31:0] prdata;
    } state_t;

    state_t q;
    state_t d;
    logic sub_rise;
    logic low_rise;
    logic half_t;
    logic sec_t;
    logic level;

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic reg_known(input logic [7:0] a);
        return (a[1:0] == 2'b00) && (a <= OFF_REGEN);
    endfunction

    function automatic logic [4:0] days_in(input logic [3:0] m, input logic [6:0] y);
        logic [4:0] n;
        n = 5'h1F;
        if (m == 4'h4 || m == 4'h6 || m == 4'h9 || m == 4'hB) begin
            n = 5'h1E;
        end else if (m == MONTH_FEB) begin
            n = (y[1:0] == 2'b00) ? 5'h1D : 5'h1C;
        end
        return n;
    endfunction

    function automatic logic [21:0] lp_limit(input logic [2:0] s);
        logic [21:0] n;
        n = LP_MONTH_SECS;
        if (s == PER_MIN) begin
            n = LP_MIN_SECS;
        end else if (s == PER_HOUR) begin
            n = LP_HOUR_SECS;
        end else if (s == PER_DAY) begin
            n = LP_DAY_SECS;
        end
        return n;
    endfunction

    // ****************************************
    // clock sources and prescaler
    // ****************************************
    pin_edge_sync u_sub_sync (
        .core_clk_i(core_clk_i),
        .reset_n_i(reset_n_i),
        .pin_i(sub_clk_i),
        .rise_o(sub_rise)
    );

    pin_edge_sync u_low_sync (
        .core_clk_i(core_clk_i),
        .reset_n_i(reset_n_i),
        .pin_i(low_speed_osc_clock_i),
        .rise_o(low_rise)
    );

    // low-speed ticks stretch every period by the clock ratio
    second_prescaler u_presc (
        .core_clk_i(core_clk_i),
        .reset_n_i(reset_n_i),
        .run_i(q.ctrl.run),
        .tick_i(q.ctrl.clk_low ? low_rise : sub_rise),
        .hi_acc_i(q.ctrl.hi_acc & fast_onchip_oscillator_on_i),
        .corr_i(q.corr),
        .half_o(half_t),
        .sec_o(sec_t),
        .level_o(level)
    );

    // ****************************************
    // next-state logic
    // ****************************************
    logic cal_run;
    logic c_min;
    logic c_hour;
    logic c_day;
    logic c_mon;
    logic lp_ev;
    logic alm_now;
    logic wr;
    logic wr_ok;
    logic [2:0] ev;
    logic [31:0] rd;

    always_comb begin
        d = q;
        d.per_pulse = 1'b0;
        d.conv_trig = 1'b0;
        c_min = 1'b0;
        c_hour = 1'b0;
        c_day = 1'b0;
        c_mon = 1'b0;
        lp_ev = 1'b0;
        ev = 3'b000;
        cal_run = q.ctrl.run && !q.ctrl.clk_low && sec_t;

        // calendar cascade
        if (cal_run) begin
            if (q.cal.sec >= SEC_MAX) begin
                d.cal.sec = '0;
                c_min = 1'b1;
            end else begin
                d.cal.sec = q.cal.sec + 6'h01;
            end
        end
        if (c_min) begin
            if (q.cal.min >= MIN_MAX) begin
                d.cal.min = '0;
                c_hour = 1'b1;
            end else begin
                d.cal.min = q.cal.min + 6'h01;
            end
        end
        if (c_hour) begin
            if (q.cal.hour >= HOUR_MAX) begin
                d.cal.hour = '0;
                c_day = 1'b1;
            end else begin
                d.cal.hour = q.cal.hour + 5'h01;
            end
        end
        if (c_day) begin
            d.cal.week = (q.cal.week >= WEEK_MAX) ? 3'h0 : q.cal.week + 3'h1;
            if (q.cal.date >= days_in(q.cal.month, q.cal.year)) begin
                d.cal.date = 5'h01;
                c_mon = 1'b1;
            end else begin
                d.cal.date = q.cal.date + 5'h01;
            end
        end
        if (c_mon) begin
            if (q.cal.month >= MONTH_MAX) begin
                d.cal.month = 4'h1;
                d.cal.year = (q.cal.year >= YEAR_MAX) ? 7'h00 : q.cal.year + 7'h01;
            end else begin
                d.cal.month = q.cal.month + 4'h1;
            end
        end

        // low-speed periodic second counter
        if (!q.ctrl.run || !q.ctrl.clk_low) begin
            d.lp_cnt = '0;
        end else if (sec_t) begin
            if (q.lp_cnt >= lp_limit(q.ctrl.per_sel) - 22'h000001) begin
                d.lp_cnt = '0;
                lp_ev = 1'b1;
            end else begin
                d.lp_cnt = q.lp_cnt + 22'h000001;
            end
        end

        // periodic event selection
        if (q.ctrl.run) begin
            unique case (q.ctrl.per_sel)
                PER_OFF: ev[EV_PER] = 1'b0;
                PER_HALF: ev[EV_PER] = half_t | sec_t;
                PER_SEC: ev[EV_PER] = sec_t;
                PER_MIN: ev[EV_PER] = q.ctrl.clk_low ? lp_ev : c_min;
                PER_HOUR: ev[EV_PER] = q.ctrl.clk_low ? lp_ev : c_hour;
                PER_DAY: ev[EV_PER] = q.ctrl.clk_low ? lp_ev : c_day;
                PER_MONTH: ev[EV_PER] = q.ctrl.clk_low ? lp_ev : c_mon;
                default: ev[EV_PER] = 1'b0;
            endcase
        end
        d.per_pulse = ev[EV_PER];
        ev[EV_FETCH] = q.ctrl.run && sec_t;

        // alarm compare, edge of match
        alm_now = q.ctrl.alm_en && q.ctrl.run && !q.ctrl.clk_low
            && (q.cal.week <= WEEK_MAX) && q.alm.week[q.cal.week]
            && (q.cal.hour == q.alm.hour) && (q.cal.min == q.alm.min);
        d.alm_hit = alm_now;
        ev[EV_ALM] = alm_now && !q.alm_hit;

        // apb write
        wr = psel_i && penable_i && pwrite_i;
        wr_ok = wr && q.reg_en;
        if (wr) begin
            unique case (paddr_i)
                OFF_CTRL: if (wr_ok) d.ctrl = ctrl_t'(pwdata_i[7:0]);
                OFF_SEC: if (wr_ok) d.cal.sec = pwdata_i[5:0];
                OFF_MIN: if (wr_ok) d.cal.min = pwdata_i[5:0];
                OFF_HOUR: if (wr_ok) d.cal.hour = pwdata_i[4:0];
                OFF_DATE: if (wr_ok) d.cal.date = pwdata_i[4:0];
                OFF_WEEK: if (wr_ok) d.cal.week = pwdata_i[2:0];
                OFF_MONTH: if (wr_ok) d.cal.month = pwdata_i[3:0];
                OFF_YEAR: if (wr_ok) d.cal.year = pwdata_i[6:0];
                OFF_CORR: if (wr_ok) d.corr = pwdata_i[15:0];
                OFF_AMIN: if (wr_ok) d.alm.min = pwdata_i[5:0];
                OFF_AHOUR: if (wr_ok) d.alm.hour = pwdata_i[4:0];
                OFF_AWEEK: if (wr_ok) d.alm.week = pwdata_i[6:0];
                OFF_STAT: d.stat = q.stat & ~pwdata_i[2:0];
                OFF_MASK: d.mask = pwdata_i[2:0];
                OFF_REGEN: d.reg_en = pwdata_i[0];
                default: d.reg_en = q.reg_en;
            endcase
        end

        // sticky status, a new event beats the clear
        d.stat = d.stat | ev;
        d.irq = |(d.stat & d.mask);
        d.conv_trig = |(ev & q.mask);
        // pin level re-registered so the enable gate cannot glitch it
        d.one_hz = q.ctrl.out_en && level;

        // read data captured in the setup cycle
        rd = 32'h0000_0000;
        unique case (paddr_i)
            OFF_CTRL: rd[7:0] = q.ctrl;
            OFF_SEC: rd[5:0] = q.cal.sec;
            OFF_MIN: rd[5:0] = q.cal.min;
            OFF_HOUR: rd[4:0] = q.cal.hour;
            OFF_DATE: rd[4:0] = q.cal.date;
            OFF_WEEK: rd[2:0] = q.cal.week;
            OFF_MONTH: rd[3:0] = q.cal.month;
            OFF_YEAR: rd[6:0] = q.cal.year;
            OFF_CORR: rd[15:0] = q.corr;
            OFF_AMIN: rd[5:0] = q.alm.min;
            OFF_AHOUR: rd[4:0] = q.alm.hour;
            OFF_AWEEK: rd[6:0] = q.alm.week;
            OFF_STAT: rd[2:0] = q.stat;
            OFF_MASK: rd[2:0] = q.mask;
            OFF_REGEN: rd[0] = q.reg_en;
            default: rd = 32'h0000_0000;
        endcase
        if (psel_i && !penable_i) begin
            d.prdata = rd;
        end
    end

    // ****************************************
    // state register
    // ****************************************
    // calendar and alarm fields take no reset at all
    always_ff @(posedge core_clk_i) begin
        q.cal <= d.cal;
        q.alm <= d.alm;
        // control and correction survive every reset but power-on
        if (!por_n_i) begin
            q.ctrl <= CTRL_RST;
            q.corr <= CORR_RST;
        end else begin
            q.ctrl <= d.ctrl;
            q.corr <= d.corr;
        end
        // event state clears on either reset
        if (!reset_n_i || !por_n_i) begin
            q.reg_en <= 1'b0;
            q.stat <= '0;
            q.mask <= '0;
            q.alm_hit <= 1'b0;
            q.lp_cnt <= '0;
            q.per_pulse <= 1'b0;
            q.conv_trig <= 1'b0;
            q.irq <= 1'b0;
            q.one_hz <= 1'b0;
            q.prdata <= '0;
        end else begin
            q.reg_en <= d.reg_en;
            q.stat <= d.stat;
            q.mask <= d.mask;
            q.alm_hit <= d.alm_hit;
            q.lp_cnt <= d.lp_cnt;
            q.per_pulse <= d.per_pulse;
            q.conv_trig <= d.conv_trig;
            q.irq <= d.irq;
            q.one_hz <= d.one_hz;
            q.prdata <= d.prdata;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign prdata_o = q.prdata;
    assign pready_o = 1'b1;
    assign pslverr_o = psel_i && penable_i && !reg_known(paddr_i);
    assign clock_event_interrupt_o = q.irq;
    assign wake_request_o = q.irq;
    assign converter_low_power_mode_o = q.conv_trig;
    assign periodic_pulse_o = q.per_pulse;
    assign one_hz_o = q.one_hz;
endmodule

// >>> rtc_monitor.sv
// concurrent checks on the calendar clock unit ports
`timescale 1ns/10ps
module rtc_monitor (
    input wire logic core_clk_i, // core clock
    input wire logic reset_n_i, // sync reset, active low
    input wire logic psel_i, // apb select
    input wire logic penable_i, // apb enable
    input wire logic pwrite_i, // apb write
    input wire logic [7:0] paddr_i, // apb address
    input wire logic [31:0] prdata_o, // apb read data
    input wire logic pready_o, // apb ready
    input wire logic pslverr_o, // apb error
    input wire logic clock_event_interrupt_o, // level interrupt
    input wire logic wake_request_o, // wakeup level
    input wire logic converter_low_power_mode_o, // converter trigger
    input wire logic periodic_pulse_o, // periodic pulse
    input wire logic one_hz_o // 1 Hz pin
);
    logic bad_addr;
    assign bad_addr = (paddr_i > 8'h38) || (paddr_i[1:0] != 2'h0);
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!reset_n_i);
    AST_READY: assert property (pready_o)
        else $error("ready dropped");
    AST_ERR_ACCESS: assert property (psel_i && penable_i |-> pslverr_o == bad_addr)
        else $error("error flag wrong in access");
    AST_ERR_IDLE: assert property (!(psel_i && penable_i) |-> !pslverr_o)
        else $error("error flag outside access");
    AST_BAD_READ_ZERO: assert property (psel_i && !penable_i && !pwrite_i && bad_addr
        |=> prdata_o == 32'h0)
        else $error("unmapped read not zero");
    AST_WAKE_EQ_IRQ: assert property (wake_request_o == clock_event_interrupt_o)
        else $error("wake differs from interrupt");
    AST_PER_ONE_CYCLE: assert property (periodic_pulse_o |=> !periodic_pulse_o)
        else $error("periodic pulse too long");
    AST_LPM_ONE_CYCLE: assert property (converter_low_power_mode_o |=> !converter_low_power_mode_o)
        else $error("converter pulse too long");
    AST_LPM_IRQ: assert property (converter_low_power_mode_o |-> ##[0:2] clock_event_interrupt_o)
        else $error("converter pulse without interrupt");
    AST_HZ_HOLD: assert property ($rose(one_hz_o) |=> one_hz_o [*8])
        else $error("1 Hz high phase too short");
    AST_RESET_QUIET: assert property (disable iff (1'b0) !reset_n_i
        |=> !periodic_pulse_o && !converter_low_power_mode_o && !clock_event_interrupt_o)
        else $error("event outputs active after reset");
endmodule

// >>> testbench.sv
// self-checking bench for the calendar clock unit
`timescale 1ns/10ps
module testbench;
    import rtc_pkg::*;
    logic core_clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic por_n_i = 1'b0;
    logic sub_clk_i = 1'b0;
    logic low_speed_osc_clock_i = 1'b0;
    logic fast_onchip_oscillator_on_i = 1'b0;
    logic psel_i = 1'b0;
    logic penable_i = 1'b0;
    logic pwrite_i = 1'b0;
    logic [7:0] paddr_i = 8'h00;
    logic [31:0] pwdata_i = 32'h0;
    logic [31:0] prdata_o;
    logic pready_o, pslverr_o, clock_event_interrupt_o, wake_request_o;
    logic converter_low_power_mode_o, periodic_pulse_o, one_hz_o;
    logic [3:0] div_q = 4'h0;
    logic [31:0] rd, sv;
    logic err;
    logic [31:0] t_dt [2] = '{32'h1C, 32'h1F};
    logic [31:0] t_mo [2] = '{32'h2, 32'hC};
    logic [31:0] t_yr [2] = '{32'h5, 32'h63};
    logic [31:0] e_mo [2] = '{32'h3, 32'h1};
    logic [31:0] e_yr [2] = '{32'h5, 32'h0};
    int n_mismatch = 0;
    int checks = 0;
    int gap;

    defparam u_dut.u_presc.TICKS = 16;
    calendar_clock_unit u_dut (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i),
        .por_n_i(por_n_i), .sub_clk_i(sub_clk_i), .low_speed_osc_clock_i(low_speed_osc_clock_i),
        .fast_onchip_oscillator_on_i(fast_onchip_oscillator_on_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
        .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
        .clock_event_interrupt_o(clock_event_interrupt_o), .wake_request_o(wake_request_o),
        .converter_low_power_mode_o(converter_low_power_mode_o),
        .periodic_pulse_o(periodic_pulse_o), .one_hz_o(one_hz_o));

    initial begin
        forever #20 core_clk_i = ~core_clk_i;
    end
    // oscillator pins: subsystem tick every 4 cycles, low-speed every 8
    always @(posedge core_clk_i) begin
        div_q <= div_q + 4'h1;
        sub_clk_i <= div_q[1];
        low_speed_osc_clock_i <= div_q[2];
    end

    // ****************************************
    // tasks
    // ****************************************
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic timed_out();
        n_mismatch++;
        $display("mismatch at %0t: wait timed out", $time);
        print_verdict();
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge core_clk_i);
        psel_i <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge core_clk_i);
        penable_i <= 1'b1;
        do begin
            @(posedge core_clk_i);
            n++;
        end while (pready_o !== 1'b1 && n < 16);
        if (n >= 16) timed_out();
        rd = prdata_o;
        err = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(rd, exp);
    endtask
    task automatic set_cal(input logic [31:0] s, m, h, d, mo, y);
        wr(OFF_DATE, d);
        wr(OFF_MONTH, mo);
        wr(OFF_YEAR, y);
        wr(OFF_HOUR, h);
        wr(OFF_MIN, m);
        wr(OFF_SEC, s);
    endtask
    // gap holds cycles since the call started
    task automatic wait_pulse(input int bound);
        int n;
        n = 0;
        do begin
            @(negedge core_clk_i);
            n++;
        end while (periodic_pulse_o !== 1'b1 && n < bound);
        if (n >= bound) timed_out();
        gap = n;
    endtask
    task automatic no_pulse(input int cyc);
        logic seen;
        seen = 1'b0;
        repeat (cyc) begin
            @(negedge core_clk_i);
            seen = seen | periodic_pulse_o;
        end
        check({31'h0, seen}, 32'h0);
    endtask
    task automatic hz_high();
        int n;
        n = 0;
        while (one_hz_o !== 1'b0 && n < 200) begin @(negedge core_clk_i); n++; end
        while (one_hz_o !== 1'b1 && n < 200) begin @(negedge core_clk_i); n++; end
        if (n >= 200) timed_out();
        gap = 0;
        while (one_hz_o === 1'b1 && gap < 200) begin @(negedge core_clk_i); gap++; end
    endtask

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        repeat (8) @(posedge core_clk_i);
        reset_n_i <= 1'b1;
        por_n_i <= 1'b1;
        rdc(OFF_CTRL, 32'h0);
        rdc(OFF_CORR, 32'h0);
        rdc(OFF_REGEN, 32'h0);
        wr(OFF_CTRL, 32'h25);
        rdc(OFF_CTRL, 32'h0);
        apb(1'b0, 8'h3C, 32'h0);
        check({err, rd[30:0]}, 32'h80000000);
        apb(1'b0, 8'h05, 32'h0);
        check({31'h0, err}, 32'h1);
        wr(OFF_REGEN, 32'h1);
        set_cal(32'h3A, 32'h3B, 32'h17, 32'h1C, 32'h2, 32'h4);
        wr(OFF_WEEK, 32'h6);
        wr(OFF_AMIN, 32'h0);
        wr(OFF_AHOUR, 32'h0);
        wr(OFF_AWEEK, 32'h1);
        wr(OFF_CTRL, 32'hA5);
        wait_pulse(200);
        wait_pulse(100);
        rdc(OFF_SEC, 32'h0);
        rdc(OFF_MIN, 32'h0);
        rdc(OFF_HOUR, 32'h0);
        rdc(OFF_WEEK, 32'h0);
        rdc(OFF_DATE, 32'h1D);
        rdc(OFF_YEAR, 32'h4);
        rdc(OFF_STAT, 32'h7);
        check({31'h0, clock_event_interrupt_o}, 32'h0);
        wr(OFF_MASK, 32'h2);
        repeat (2) @(negedge core_clk_i);
        check({wake_request_o, clock_event_interrupt_o}, 32'h3);
        wr(OFF_STAT, 32'h7);
        wr(OFF_MASK, 32'h1);
        rdc(OFF_STAT, 32'h0);
        wait_pulse(100);
        check({31'h0, converter_low_power_mode_o}, 32'h1);
        @(negedge core_clk_i);
        check({31'h0, periodic_pulse_o}, 32'h0);
        @(negedge core_clk_i);
        check({31'h0, clock_event_interrupt_o}, 32'h1);
        for (int i = 0; i < 2; i++) begin
            set_cal(32'h3B, 32'h3B, 32'h17, t_dt[i], t_mo[i], t_yr[i]);
            wait_pulse(100);
            rdc(OFF_DATE, 32'h1);
            rdc(OFF_MONTH, e_mo[i]);
            rdc(OFF_YEAR, e_yr[i]);
        end
        for (int i = 0; i < 2; i++) begin
            wr(OFF_CTRL, (i == 0) ? 32'h15 : 32'h25);
            wait_pulse(100);
            wait_pulse(100);
            check(gap, (i == 0) ? 32'h20 : 32'h40);
        end
        for (int i = 3; i < 7; i++) begin
            wr(OFF_CTRL, 32'h25);
            wait_pulse(100);
            set_cal(32'h3B, 32'h3B, 32'h17, 32'h1F, 32'hC, 32'h5);
            wr(OFF_CTRL, {24'h0, 1'b0, 3'(i), 4'h5});
            wait_pulse(100);
            rdc(OFF_SEC, 32'h0);
            no_pulse(80);
        end
        wr(OFF_CTRL, 32'h25);
        hz_high();
        check(gap, 32'h20);
        @(posedge core_clk_i);
        fast_onchip_oscillator_on_i <= 1'b1;
        wr(OFF_CORR, 32'h4);
        wr(OFF_CTRL, 32'h2D);
        repeat (3) wait_pulse(200);
        check(gap, 32'h50);
        @(posedge core_clk_i);
        fast_onchip_oscillator_on_i <= 1'b0;
        repeat (3) wait_pulse(200);
        check(gap, 32'h40);
        wr(OFF_CTRL, 32'h27);
        apb(1'b0, OFF_SEC, 32'h0);
        sv = rd;
        repeat (2) wait_pulse(300);
        check(gap, 32'h80);
        rdc(OFF_SEC, sv);
        wr(OFF_CTRL, 32'h37);
        repeat (2) wait_pulse(8000);
        check(gap, 32'h1E00);
        @(posedge core_clk_i);
        reset_n_i <= 1'b0;
        repeat (2) @(posedge core_clk_i);
        reset_n_i <= 1'b1;
        rdc(OFF_REGEN, 32'h0);
        rdc(OFF_CTRL, 32'h37);
        rdc(OFF_CORR, 32'h4);
        rdc(OFF_AWEEK, 32'h1);
        @(posedge core_clk_i);
        por_n_i <= 1'b0;
        repeat (2) @(posedge core_clk_i);
        por_n_i <= 1'b1;
        rdc(OFF_CTRL, 32'h0);
        rdc(OFF_CORR, 32'h0);
        rdc(OFF_SEC, sv);
        print_verdict();
    end
endmodule

bind calendar_clock_unit rtc_monitor u_mon (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .clock_event_interrupt_o(clock_event_interrupt_o), .wake_request_o(wake_request_o),
    .converter_low_power_mode_o(converter_low_power_mode_o),
    .periodic_pulse_o(periodic_pulse_o), .one_hz_o(one_hz_o));
